// *** core/pin_sync.v ***
// two-flop synchroniser for pins entering the ref_clk domain
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter WIDTH = 3
) (
    input wire ref_clk,
    input wire arst_n,
    input wire [WIDTH-1:0] pin_in,
    output reg [WIDTH-1:0] pin_out
);

reg [WIDTH-1:0] meta_r;

// first stage feeds only the second
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        meta_r <= {WIDTH{1'b0}};
        pin_out <= {WIDTH{1'b0}};
    end
    else
    begin
        meta_r <= pin_in;
        pin_out <= meta_r;
    end
end

endmodule // pin_sync

`default_nettype wire

// *** core/spi_frame_responder.v ***
// device-side serial frame handler with command decode and answers
`timescale 1ns/1ns
`default_nettype none
`include "spi_frame_responder_regs.vh"

module spi_frame_responder (
    input wire ref_clk,
    input wire arst_n,
    input wire chip_select_low,
    input wire sclk,
    input wire sdi,
    output reg sdo,
    output wire sdo_oe,
    input wire sw_reset,
    input wire [15:0] diag_in,
    input wire [1:0] in_pins,
    output reg [3:0] out_ctrl_r,
    output reg [3:0] map0_r,
    output reg [3:0] map1_r,
    output reg transfer_fault_flag
);

////////////////////////////////////////////////////////////////////////
// pin synchronisation and edge detection

wire [2:0] pins_s;
wire cs_n_s;
wire sclk_s;
wire sdi_s;
reg cs_n_d_r;
reg sclk_d_r;

// chip select enters inverted so the cleared synchroniser reads as deselected
pin_sync #(.WIDTH(3)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in({~chip_select_low, sclk, sdi}),
    .pin_out(pins_s)
);

// no false select edge after reset
assign cs_n_s = ~pins_s[2];
assign sclk_s = pins_s[1];
assign sdi_s = pins_s[0];

// delayed copies for edge finding
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        cs_n_d_r <= 1'b1;
        sclk_d_r <= 1'b0;
    end
    else
    begin
        cs_n_d_r <= cs_n_s;
        sclk_d_r <= sclk_s;
    end
end

wire cs_fall = cs_n_d_r & ~cs_n_s;
wire cs_rise = ~cs_n_d_r & cs_n_s;
wire active = ~cs_n_s;
wire sclk_fall = active & sclk_d_r & ~sclk_s;
wire sclk_rise = active & ~sclk_d_r & sclk_s;

////////////////////////////////////////////////////////////////////////
// frame decode helpers

// legal clock count: 16, 24 or 32
function count_ok;
    input [7:0] cnt;
    begin
        count_ok = (cnt >= `CNT_MIN) && (cnt <= `CNT_MAX) && (cnt[2:0] == 3'h0);
    end
endfunction

// location exists in the register map and, for a write, is not the input state register
function loc_ok;
    input [5:0] loc;
    input is_write;
    begin
        case (loc)
            `LOC_OUT, `LOC_MAP0, `LOC_MAP1: loc_ok = 1'b1;
            `LOC_INPUT_STATE_REG: loc_ok = ~is_write;
            default: loc_ok = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////
// shift register and clock counter

reg [15:0] shift_r;
reg [7:0] count_r;
reg [1:0] ans_kind_r;
reg [5:0] ans_loc_r;
reg [15:0] answer;
reg [3:0] reg_val;

// content of the addressed register
always @*
begin
    case (ans_loc_r)
        `LOC_OUT: reg_val = out_ctrl_r;
        `LOC_MAP0: reg_val = map0_r;
        `LOC_MAP1: reg_val = map1_r;
        default: reg_val = 4'h0;
    endcase
end

// answer word built when the next transfer opens
always @*
begin
    answer = diag_in;
    answer[`FAULT_BIT] = transfer_fault_flag;
    case (ans_kind_r)
        `ANS_REG: answer = (ans_loc_r == `LOC_INPUT_STATE_REG) ? {`CMD_WRITE, `LOC_INPUT_STATE_REG, transfer_fault_flag, 5'h00, in_pins}
            : {`CMD_WRITE, ans_loc_r, 4'h0, reg_val};
        `ANS_ERR: answer[`FAULT_BIT] = 1'b1;
        `ANS_RST: answer = {`CMD_WRITE, `LOC_INPUT_STATE_REG, 1'b1, 5'h00, in_pins};
        default: answer[`FAULT_BIT] = transfer_fault_flag;
    endcase
end

// shift in on falling, present msb on rising
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        shift_r <= 16'h0000;
        count_r <= 8'h00;
        sdo <= 1'b0;
    end
    else if (cs_fall)
    begin
        shift_r <= answer;
        sdo <= answer[15];
        count_r <= 8'h00;
    end
    else if (sclk_fall)
    begin
        shift_r <= {shift_r[14:0], sdi_s};
        if (count_r != 8'hFF)
            count_r <= count_r + 8'h01;
    end
    else if (sclk_rise)
    begin
        sdo <= shift_r[15];
    end
end

assign sdo_oe = active;

////////////////////////////////////////////////////////////////////////
// frame acceptance on chip select release

wire [1:0] cmd = shift_r[15:14];
wire [5:0] loc = shift_r[13:8];
wire good_len = count_ok(count_r);
wire diag_cmd = (cmd == `CMD_DIAG) && (shift_r[1:0] != `READ_TAIL);
wire read_cmd = (cmd == `CMD_READ) && loc_ok(loc, 1'b0);
wire write_cmd = (cmd == `CMD_WRITE) && loc_ok(loc, 1'b1);

// decide next answer and update registers
always @(posedge ref_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        ans_kind_r <= `ANS_RST;
        ans_loc_r <= `LOC_INPUT_STATE_REG;
        transfer_fault_flag <= 1'b1;
        out_ctrl_r <= `RST_OUT;
        map0_r <= `RST_MAP0;
        map1_r <= `RST_MAP1;
    end
    else if (sw_reset)
    begin
        ans_kind_r <= `ANS_RST;
        ans_loc_r <= `LOC_INPUT_STATE_REG;
        transfer_fault_flag <= 1'b1;
        out_ctrl_r <= `RST_OUT;
        map0_r <= `RST_MAP0;
        map1_r <= `RST_MAP1;
    end
    else if (cs_rise)
    begin
        transfer_fault_flag <= ~good_len;
        ans_loc_r <= loc;
        if (!good_len)
        begin
            ans_kind_r <= `ANS_DIAG;
        end
        else if (read_cmd)
        begin
            ans_kind_r <= `ANS_REG;
        end
        else if (write_cmd)
        begin
            ans_kind_r <= `ANS_DIAG;
            case (loc)
                `LOC_OUT: out_ctrl_r <= shift_r[3:0];
                `LOC_MAP0: map0_r <= shift_r[3:0];
                default: map1_r <= shift_r[3:0];
            endcase
        end
        else if (diag_cmd)
        begin
            ans_kind_r <= `ANS_DIAG;
        end
        else
        begin
            ans_kind_r <= `ANS_ERR;
        end
    end
end

endmodule // spi_frame_responder

`default_nettype wire

// *** inc/spi_frame_responder_regs.vh ***
// constants for the serial frame responder
// Behaviour
// - answer to a command goes out during the next host transfer
// - clock count not a multiple of 8 or below 16 is a transfer error
// - first answer after power-on or software reset is a special reset answer
// - write starting 11 or read starting 00 is a syntax error, answered with error
// - access to reserved or unused register location is a syntax error
// - write frame 10, 4+2 address bits, 8 data bits; store, answer diagnosis
// - read frame 01 plus addresses; answer 10, echoed addresses, register content
// - serial input sampled on falling serial clock edge
// - serial output driven only while chip select is low
// - frame acted on only when chip select rises at transfer end
// - fault flag clear only after 16, 24 or 32 clocks, otherwise set
// - first frame after logic reset is input state register with fault flag set
`ifndef SPI_FRAME_RESPONDER_REGS_VH
`define SPI_FRAME_RESPONDER_REGS_VH

// command codes in frame bits 15:14
`define CMD_DIAG 2'h0
`define CMD_READ 2'h1
`define CMD_WRITE 2'h2
`define CMD_BAD 2'h3
// read marker in bits 1:0 of a read frame
`define READ_TAIL 2'h2
// register locations {primary, secondary}
`define LOC_OUT 6'h00
`define LOC_MAP0 6'h04
`define LOC_MAP1 6'h05
`define LOC_INPUT_STATE_REG 6'h06
// reset values of writable registers
`define RST_OUT 4'h0
`define RST_MAP0 4'h4
`define RST_MAP1 4'h8
// fault flag position in the diagnosis word
`define FAULT_BIT 10
// legal clock counts per transfer
`define CNT_MIN 8'h10
`define CNT_MAX 8'h20
// answer kinds
`define ANS_DIAG 2'h0
`define ANS_REG 2'h1
`define ANS_ERR 2'h2
`define ANS_RST 2'h3

`endif

// *** tb/spi_frame_responder_sva.sv ***
// port checker for the serial frame responder
`timescale 1ns/1ns
`default_nettype none
module spi_frame_responder_sva (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic chip_select_low,
    input wire logic sclk,
    input wire logic sw_reset,
    input wire logic sdo,
    input wire logic sdo_oe,
    input wire logic [3:0] out_ctrl_r,
    input wire logic [3:0] map0_r,
    input wire logic [3:0] map1_r,
    input wire logic transfer_fault_flag
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    chk_oe_off: assert property (chip_select_low [*4] |-> !sdo_oe)
        else $error("sdo enabled while deselected");
    chk_oe_on: assert property (!chip_select_low [*4] |-> sdo_oe)
        else $error("sdo idle while selected");
    chk_sdo_hold: assert property ((!chip_select_low && !sclk) [*6] |-> $stable(sdo))
        else $error("sdo moved without clock rise");
    chk_reg_frame: assert property ($changed({out_ctrl_r, map0_r, map1_r}) |-> $past(sw_reset || chip_select_low))
        else $error("register moved inside a frame");
    chk_flag_frame: assert property ($changed(transfer_fault_flag) |-> $past(sw_reset || chip_select_low))
        else $error("fault flag moved inside a frame");
    chk_sel_hold: assert property ((!chip_select_low && !sw_reset) [*4] |-> $stable(map0_r))
        else $error("register moved while selected");
    chk_reset_vals: assert property ($rose(arst_n) |-> transfer_fault_flag && map0_r == 4'h4 && map1_r == 4'h8)
        else $error("wrong values after reset");
    chk_sw_reset: assert property (sw_reset |=> transfer_fault_flag && out_ctrl_r == 4'h0 && map1_r == 4'h8)
        else $error("software reset not applied");
endmodule // spi_frame_responder_sva
bind spi_frame_responder spi_frame_responder_sva u_sva (.ref_clk, .arst_n, .chip_select_low, .sclk, .sw_reset, .sdo,
    .sdo_oe, .out_ctrl_r, .map0_r, .map1_r, .transfer_fault_flag);
`default_nettype wire

// *** tb/spi_host_model.sv ***
// host serial master model: sends frames, collects answers
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
    input wire logic ref_clk,
    input wire logic sdo,
    output logic chip_select_low,
    output logic sclk,
    output logic sdi,
    output logic [15:0] resp
);
    event done;
    // idle levels
    initial
    begin
        chip_select_low = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
        resp = 16'h0000;
    end
    // data moves on the rise, away from sampling
    // chip select raised to close each frame
    task xfer(input [31:0] f, input integer n);
        integer i;
        begin
            @(negedge ref_clk) chip_select_low = 1'b0;
            resp = 16'h0000;
            repeat (6) @(negedge ref_clk);
            for (i = n - 1; i >= 0; i--)
            begin
                sclk = 1'b1;
                sdi = f[i];
                repeat (6) @(negedge ref_clk);
                // answer bit read before the fall, after the device drove it onto sdo on the rise
                if (i >= n - 16)
                    resp = {resp[14:0], sdo};
                sclk = 1'b0;
                repeat (6 + i % 2) @(negedge ref_clk);
            end
            // short frame: received bits stand at the top
            if (n < 16)
                resp = resp << (16 - n);
            chip_select_low = 1'b1;
            sdi = ~sdi;
            repeat (8) @(negedge ref_clk);
            -> done;
        end
    endtask
endmodule // spi_host_model
`default_nettype wire

// *** tb/test_spi_frame_responder.sv ***
// self-checking bench for the serial frame responder
`timescale 1ns/1ns
`default_nettype none
module test_spi_frame_responder;
    logic ref_clk, arst_n, sw_reset, chip_select_low, sclk, sdi, sdo, sdo_oe, flag;
    logic [15:0] diag_in, resp;
    logic [1:0] in_pins;
    logic [3:0] out_ctrl_r, map0_r, map1_r, v;
    logic [31:0] seed = 32'h7B43;
    logic [15:0] q[$];
    logic [15:0] bad[4] = '{16'hC000, 16'h0002, 16'h8603, 16'h4E02};
    integer errors = 0, total_checks = 0, i;
    spi_frame_responder dut (.ref_clk, .arst_n, .chip_select_low, .sclk, .sdi, .sdo, .sdo_oe, .sw_reset, .diag_in,
        .in_pins, .out_ctrl_r, .map0_r, .map1_r, .transfer_fault_flag(flag));
    spi_host_model host (.ref_clk, .sdo, .chip_select_low, .sclk, .sdi, .resp);
    function [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function [15:0] dg(input f);
        return {diag_in[15:11], f, diag_in[9:0]};
    endfunction
    task chk(input string nm, input [15:0] seen, input [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // expected answer noted before each frame
    task tx(input [31:0] f, input integer n, input [15:0] e);
        q.push_back(n < 16 ? e & ~(16'hFFFF >> n) : e);
        host.xfer(f, n);
    endtask
    task print_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // answer monitor
    always @(host.done) chk("answer", resp, q.pop_front());
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // watchdog
    initial
    begin
        #400000;
        errors++;
        print_verdict();
    end
    initial
    begin
        arst_n = 1'b0;
        sw_reset = 1'b0;
        diag_in = 16'(rnd());
        in_pins = 2'(rnd());
        v = 4'(rnd());
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        tx(0, 16, {14'h21A0, in_pins});
        // write then read back over 32 clocks
        tx({12'h800, v}, 16, dg(0));
        tx(32'h4002, 16, dg(0));
        tx(0, 32, {12'h800, v});
        chk("out", {12'h0, out_ctrl_r}, {12'h0, v});
        $display("write and read test done");
        for (i = 0; i < 4; i++) tx(32'h8403, i ? 4 + 8 * i : 8, dg(i > 0));
        chk("flag", {15'h0, flag}, 16'h0001);
        tx(0, 16, dg(1));
        chk("flag", {15'h0, flag}, 16'h0000);
        chk("map0", {12'h0, map0_r}, 16'h0004);
        tx({12'h5A8, 8'h50, v}, 24, dg(0));
        tx(0, 16, dg(0));
        chk("map1", {12'h0, map1_r}, {12'h0, v});
        $display("clock count test done");
        for (i = 0; i < 8; i++) tx(i % 2 ? 0 : bad[i / 2], 16, dg(i % 2));
        chk("map0", {12'h0, map0_r}, 16'h0004);
        $display("syntax test done");
        in_pins = 2'(rnd());
        @(negedge ref_clk) sw_reset = 1'b1;
        @(negedge ref_clk) sw_reset = 1'b0;
        tx(0, 16, {14'h21A0, in_pins});
        chk("map1", {12'h0, map1_r}, 16'h0008);
        tx(32'h4602, 16, dg(0));
        tx(0, 16, {14'h2180, in_pins});
        $display("software reset test done");
        print_verdict();
    end
endmodule // test_spi_frame_responder
`default_nettype wire
